// ### verilog/affr_pkg.sv
// Package for the access fault frame builder and frame return sequencer.
// Assumes a 32-bit data path and a stack reached one long word at a time.
package affr_pkg;
  // Frame format codes
  localparam logic [3:0] FMT_SIX_WORD = 4'h2;
  localparam logic [3:0] FMT_FP_POST = 4'h3;
  localparam logic [3:0] FMT_ACCESS = 4'h7;
  localparam logic [3:0] FMT_FOUR_WORD = 4'h0;
  // Stack geometry in bytes
  localparam logic [31:0] FRAME_BYTES = 32'h0000003C; // 30 words
  localparam logic [31:0] TRACE_SHIFT = 32'h00000030;
  localparam logic [31:0] SIX_WORD_BYTES = 32'h0000000C;
  // Byte offsets inside the access fault frame
  localparam logic [31:0] OFS_SR = 32'h00000000;
  localparam logic [31:0] OFS_FMT = 32'h00000006;
  localparam logic [31:0] OFS_EA = 32'h00000008;
  localparam logic [31:0] OFS_SSW = 32'h0000000C;
  localparam logic [31:0] OFS_WRITEBACK3_STATUS = 32'h0000000E;
  localparam logic [31:0] OFS_WRITEBACK2_STATUS = 32'h00000010;
  localparam logic [31:0] OFS_WRITEBACK1_STATUS = 32'h00000012;
  localparam logic [31:0] OFS_FA = 32'h00000014;
  localparam logic [31:0] OFS_WRITEBACK3_ADDRESS = 32'h00000018;
  localparam logic [31:0] OFS_WRITEBACK3_DATA = 32'h0000001C;
  localparam logic [31:0] OFS_WRITEBACK2_ADDRESS = 32'h00000020;
  localparam logic [31:0] OFS_WRITEBACK2_DATA = 32'h00000024;
  localparam logic [31:0] OFS_WRITEBACK1_ADDRESS = 32'h00000028;
  localparam logic [31:0] OFS_WRITEBACK1_DATA = 32'h0000002C;
  // Status word bit positions
  localparam int SSW_CP = 15;
  localparam int SSW_CU = 14;
  localparam int SSW_CT = 13;
  localparam int SSW_CM = 12;
  localparam int SSW_MA = 11;
  localparam int SSW_ATC = 10;
  localparam int SSW_LK = 9;
  localparam int SSW_RW = 8;
  // Effective address mode codes
  localparam logic [2:0] MODE_PCREL = 3'h7;
  localparam logic [2:0] REG_PCD16 = 3'h2;
  localparam logic [2:0] REG_PCIDX = 3'h3;
  localparam logic [2:0] MODE_IDXIND = 3'h6;
  // Vector numbers for pending exceptions and the format error
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_FLINE = 8'h0B;
  localparam logic [7:0] VEC_FORMAT = 8'h0E;
  localparam logic [7:0] VEC_FP_POST = 8'h30;
  // Transfer size codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  // Fault cause reported by the memory pipeline
  typedef enum logic [1:0] {
    AFFR_CAUSE_BUS = 2'h0,
    AFFR_CAUSE_NONRES = 2'h1,
    AFFR_CAUSE_PRIV = 2'h2
  } affr_cause_t;

  // Faulted transfer description
  typedef struct packed {
    affr_cause_t cause;
    logic push;
    logic block_move;
    logic locked;
    logic read;
    logic line_fill;
    logic second_page;
    logic [1:0] size;
    logic [1:0] orig_size;
    logic [1:0] transfer_type_pins;
    logic [2:0] transfer_modifier_pins;
    logic [31:0] logical_addr;
    logic [31:0] physical_addr;
    logic [31:0] first_byte_addr;
  } affr_fault_t;

  // One pending write-back
  typedef struct packed {
    logic [7:0] status;
    logic [1:0] size;
    logic [31:0] address;
    logic [31:0] data;
  } affr_wb_t;

  // Stack word write request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } affr_stk_t;

  // Return sequencer states
  typedef enum logic [2:0] {
    AFFR_IDLE = 3'h0,
    AFFR_FETCH = 3'h1,
    AFFR_DECIDE = 3'h3,
    AFFR_SHIFT = 3'h2,
    AFFR_DONE = 3'h6
  } affr_state_t;
endpackage

// ### verilog/affr_align.sv
// Write-back data aligner for slot one (bus lanes) and slots two/three.
// Pure logic; caller supplies size code and the two low address bits.
`timescale 1ns/100ps
module affr_align
  import affr_pkg::*;
(
  // Raw register-aligned operand
  input wire logic [31:0] i_data,
  input wire logic [1:0] i_size,
  input wire logic [1:0] i_addr_lo,
  // Aligned results
  output logic [31:0] o_lane_data,
  output logic [31:0] o_reg_data
);
  logic [31:0] masked;
  logic [5:0] rot;

  // Register form keeps low byte or word; lane form rotates into place
  always_comb begin
    unique case (i_size)
      SZ_BYTE: masked = {24'h000000, i_data[7:0]};
      SZ_WORD: masked = {16'h0000, i_data[15:0]};
      default: masked = i_data;
    endcase
    unique case (i_size)
      SZ_BYTE: rot = {1'b0, 2'h3 - i_addr_lo, 3'h0};
      SZ_WORD: rot = {1'b0, 2'h2 - i_addr_lo, 3'h0};
      default: rot = {1'b0, 2'h0 - i_addr_lo, 3'h0};
    endcase
    o_reg_data = masked;
    // Rotation gives the wrap of misaligned words and longs
    o_lane_data = (masked << rot) | (masked >> (6'h20 - rot));
    if (rot == 6'h00) begin
      o_lane_data = masked;
    end
  end
endmodule // affr_align

// ### verilog/affr_core.sv
// Access fault frame builder and return-from-exception frame unwinder.
// Assumes the stack port answers one long word per cycle with no wait.
`timescale 1ns/100ps
module affr_core
  import affr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Fault capture
  input wire logic i_fault,
  input wire affr_fault_t i_fault_info,
  input wire logic i_multimove,
  input wire logic [31:0] i_calc_ea,
  input wire logic i_trace_pend,
  input wire logic i_fp_post_pend,
  input wire logic i_fp_unimpl_pend,
  input wire affr_wb_t i_wb_int,
  input wire affr_wb_t i_wb_dmu,
  input wire affr_wb_t i_wb_bus,
  // Address error capture
  input wire logic i_addr_error,
  input wire logic [31:0] i_fault_pc,
  input wire logic [31:0] i_ref_addr,
  // Return from exception
  input wire logic i_rte,
  input wire logic [31:0] i_ssp,
  input wire logic [31:0] i_stk_rdata,
  input wire logic [2:0] i_ea_mode,
  input wire logic [2:0] i_ea_reg,
  // Captured frame fields
  output logic [15:0] o_fault_status_word,
  output logic [31:0] o_fault_address,
  output logic [31:0] o_effective_address,
  output logic [7:0] o_writeback1_status,
  output logic [7:0] o_writeback2_status,
  output logic [7:0] o_writeback3_status,
  output logic [31:0] o_writeback1_address,
  output logic [31:0] o_writeback2_address,
  output logic [31:0] o_writeback3_address,
  output logic [31:0] o_writeback1_data,
  output logic [31:0] o_writeback2_data,
  output logic [31:0] o_writeback3_data,
  // Address error frame words
  output logic o_addr_frame_valid,
  output logic [31:0] o_addr_frame_pc,
  output logic [31:0] o_addr_frame_addr,
  // Stack port
  output logic [31:0] o_stk_raddr,
  output affr_stk_t o_stk_wr,
  // Return results
  output logic [31:0] o_new_ssp,
  output logic o_resume,
  output logic o_restart_move,
  output logic o_reuse_ea,
  output logic o_take_exception,
  output logic [7:0] o_vector,
  output logic o_format_error,
  output logic o_busy
);
  // All block state
  typedef struct packed {
    affr_state_t state;
    logic [1:0] idx;
    logic [31:0] sp;
    logic [15:0] fault_status_word;
    logic [3:0] fmt;
    logic [31:0] fa;
    logic [31:0] ea;
    logic [7:0] writeback1_status;
    logic [7:0] writeback2_status;
    logic [7:0] writeback3_status;
    logic [31:0] writeback1_address;
    logic [31:0] writeback2_address;
    logic [31:0] writeback3_address;
    logic [31:0] writeback1_data;
    logic [31:0] writeback2_data;
    logic [31:0] writeback3_data;
    logic aef_v;
    logic [31:0] aef_pc;
    logic [31:0] aef_addr;
    logic [31:0] raddr;
    affr_stk_t wr;
    logic [31:0] new_ssp;
    logic resume;
    logic restart;
    logic reuse;
    logic take;
    logic [7:0] vec;
    logic fmt_err;
    logic busy;
  } affr_core_st_t;

  affr_core_st_t s_q;
  affr_core_st_t s_d;
  logic [31:0] lane1;
  logic [31:0] reg2;
  logic [31:0] reg3;

  // Continuation flags in the stacked status word
  function automatic logic [3:0] cont_flags(input logic [15:0] w);
    cont_flags = {w[SSW_CP], w[SSW_CU], w[SSW_CT], w[SSW_CM]};
  endfunction

  affr_align u_align1 (
    .i_data(i_wb_bus.data),
    .i_size(i_wb_bus.size),
    .i_addr_lo(i_wb_bus.address[1:0]),
    .o_lane_data(lane1),
    .o_reg_data()
  );
  affr_align u_align2 (
    .i_data(i_wb_dmu.data),
    .i_size(i_wb_dmu.size),
    .i_addr_lo(i_wb_dmu.address[1:0]),
    .o_lane_data(),
    .o_reg_data(reg2)
  );
  affr_align u_align3 (
    .i_data(i_wb_int.data),
    .i_size(i_wb_int.size),
    .i_addr_lo(i_wb_int.address[1:0]),
    .o_lane_data(),
    .o_reg_data(reg3)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wr = '0;
    s_d.resume = 1'b0;
    s_d.restart = 1'b0;
    s_d.take = 1'b0;
    s_d.fmt_err = 1'b0;
    s_d.aef_v = 1'b0;
    if (i_fault) begin
      s_d.fault_status_word = 16'h0000;
      // flags are priority coded so only one is ever set
      if (i_fp_post_pend) begin
        s_d.fault_status_word[SSW_CP] = 1'b1;
      end else if (i_fp_unimpl_pend) begin
        s_d.fault_status_word[SSW_CU] = 1'b1;
      end else if (i_trace_pend) begin
        s_d.fault_status_word[SSW_CT] = 1'b1;
      // move flag on a data fault of the move
      end else if (i_multimove) begin
        s_d.fault_status_word[SSW_CM] = 1'b1;
      end
      // saved address goes into the frame
      s_d.ea = i_calc_ea;
      s_d.fault_status_word[SSW_ATC] = (i_fault_info.cause != AFFR_CAUSE_BUS);
      s_d.fault_status_word[SSW_MA] = (i_fault_info.cause != AFFR_CAUSE_BUS) && i_fault_info.second_page;
      s_d.fault_status_word[SSW_LK] = i_fault_info.locked;
      s_d.fault_status_word[SSW_RW] = i_fault_info.read;
      // original size, line fill reports execution unit read
      s_d.fault_status_word[6:5] = i_fault_info.line_fill ? i_fault_info.orig_size : i_fault_info.size;
      s_d.fault_status_word[4:3] = i_fault_info.transfer_type_pins;
      s_d.fault_status_word[2:0] = i_fault_info.transfer_modifier_pins;
      if (i_fault_info.push) begin
        s_d.fa = i_fault_info.physical_addr;
      end else begin
        s_d.fa = i_fault_info.first_byte_addr;
      end
      s_d.writeback3_status = i_wb_int.status;
      s_d.writeback3_address = i_wb_int.address;
      s_d.writeback3_data = reg3;
      s_d.writeback2_status = i_wb_dmu.status;
      s_d.writeback2_address = i_wb_dmu.address;
      s_d.writeback2_data = reg2;
      s_d.writeback1_status = i_wb_bus.status;
      s_d.writeback1_address = i_wb_bus.address;
      // push data is stored without realignment
      s_d.writeback1_data = i_fault_info.push ? i_wb_bus.data : lane1;
      // push or block move write leaves slot one invalid
      if (i_fault_info.push || (i_fault_info.block_move && !i_fault_info.read)) begin
        s_d.writeback1_status = 8'h00;
      end
      // push slot one address matches fault address
      if (i_fault_info.push) begin
        s_d.writeback1_address = i_fault_info.physical_addr;
      end
    end
    // address error frame with bit 0 cleared
    if (i_addr_error) begin
      s_d.aef_v = 1'b1;
      s_d.aef_pc = i_fault_pc;
      s_d.aef_addr = {i_ref_addr[31:1], 1'b0};
    end
    unique case (s_q.state)
      AFFR_IDLE: begin
        if (i_rte) begin
          s_d.sp = i_ssp;
          s_d.raddr = i_ssp + OFS_FMT - 32'h00000002;
          s_d.idx = 2'h0;
          s_d.state = AFFR_FETCH;
        end
      end
      AFFR_FETCH: begin
        // Word 1 carries format, word 3 carries status word
        if (s_q.idx == 2'h0) begin
          s_d.fmt = i_stk_rdata[15:12];
          s_d.raddr = s_q.sp + OFS_EA;
          s_d.idx = 2'h1;
        end else if (s_q.idx == 2'h1) begin
          s_d.ea = i_stk_rdata;
          s_d.raddr = s_q.sp + OFS_SSW;
          s_d.idx = 2'h2;
        end else begin
          s_d.fault_status_word = i_stk_rdata[31:16];
          s_d.state = AFFR_DECIDE;
        end
      end
      AFFR_DECIDE: begin
        s_d.state = AFFR_DONE;
        s_d.reuse = 1'b0;
        // illegal format leaves the frame untouched
        if (s_q.fmt != FMT_ACCESS) begin
          s_d.fmt_err = 1'b1;
          s_d.vec = VEC_FORMAT;
          s_d.new_ssp = s_q.sp - 32'h00000008;
        end else if (s_q.fault_status_word[SSW_CT]) begin
          s_d.idx = 2'h0;
          s_d.raddr = s_q.sp + OFS_SR;
          s_d.state = AFFR_SHIFT;
        end else begin
          s_d.new_ssp = s_q.sp + FRAME_BYTES;
          unique case (cont_flags(s_q.fault_status_word))
            4'h0: s_d.resume = 1'b1;
            // restart the move after address calculation
            4'h1: begin
              s_d.restart = 1'b1;
              // reuse stacked address for these modes
              s_d.reuse = (i_ea_mode == MODE_IDXIND) ||
                ((i_ea_mode == MODE_PCREL) &&
                ((i_ea_reg == REG_PCD16) || (i_ea_reg == REG_PCIDX)));
            end
            // floating post pending launches at once
            4'h8: begin
              s_d.take = 1'b1;
              s_d.vec = VEC_FP_POST;
            end
            4'h4: begin
              s_d.take = 1'b1;
              s_d.vec = VEC_FLINE;
            end
            // several flags set is undefined; resume here
            default: s_d.resume = 1'b1;
          endcase
        end
      end
      AFFR_SHIFT: begin
        // move three long words up by the trace shift
        s_d.wr.valid = 1'b1;
        s_d.wr.addr = s_q.raddr + TRACE_SHIFT;
        s_d.wr.data = i_stk_rdata;
        if (s_q.idx == 2'h1) begin
          s_d.wr.data = {i_stk_rdata[31:16], FMT_SIX_WORD, i_stk_rdata[11:0]};
        end
        s_d.raddr = s_q.raddr + 32'h00000004;
        s_d.idx = s_q.idx + 2'h1;
        if (s_q.idx == 2'h2) begin
          s_d.new_ssp = s_q.sp + TRACE_SHIFT;
          s_d.take = 1'b1;
          s_d.vec = VEC_TRACE;
          s_d.state = AFFR_DONE;
        end
      end
      AFFR_DONE: s_d.state = AFFR_IDLE;
      default: s_d.state = AFFR_IDLE;
    endcase
    // Busy kept as a flop so the output never glitches on state decode
    s_d.busy = (s_d.state != AFFR_IDLE);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_fault_status_word = s_q.fault_status_word;
  assign o_fault_address = s_q.fa;
  assign o_effective_address = s_q.ea;
  assign o_writeback1_status = s_q.writeback1_status;
  assign o_writeback2_status = s_q.writeback2_status;
  assign o_writeback3_status = s_q.writeback3_status;
  assign o_writeback1_address = s_q.writeback1_address;
  assign o_writeback2_address = s_q.writeback2_address;
  assign o_writeback3_address = s_q.writeback3_address;
  assign o_writeback1_data = s_q.writeback1_data;
  assign o_writeback2_data = s_q.writeback2_data;
  assign o_writeback3_data = s_q.writeback3_data;
  assign o_addr_frame_valid = s_q.aef_v;
  assign o_addr_frame_pc = s_q.aef_pc;
  assign o_addr_frame_addr = s_q.aef_addr;
  assign o_stk_raddr = s_q.raddr;
  assign o_stk_wr = s_q.wr;
  assign o_new_ssp = s_q.new_ssp;
  assign o_resume = s_q.resume;
  assign o_restart_move = s_q.restart;
  assign o_reuse_ea = s_q.reuse;
  assign o_take_exception = s_q.take;
  assign o_vector = s_q.vec;
  assign o_format_error = s_q.fmt_err;
  assign o_busy = s_q.busy;

  // a_one_flag: at most one continuation flag after capture
  a_one_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    $past(i_fault) |-> $onehot0(cont_flags(s_q.fault_status_word)))
    else $error("more than one continuation flag");
  // a_trace_pop: trace return shifts stack by 30 hex
  a_trace_pop: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_take_exception && o_vector == VEC_TRACE) |-> o_new_ssp == s_q.sp + TRACE_SHIFT)
    else $error("trace return stack adjust wrong");
  // a_trace_fmt: second shifted word carries six-word format
  a_trace_fmt: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.state == AFFR_SHIFT && s_q.idx == 2'h1) |=> o_stk_wr.data[15:12] == FMT_SIX_WORD)
    else $error("format not rewritten");
  // a_plain_pop: plain resume pops thirty words
  a_plain_pop: assert property (@(posedge i_clk) disable iff (i_reset)
    o_resume |-> o_new_ssp == s_q.sp + FRAME_BYTES)
    else $error("resume stack pop wrong");
  // a_move_pop: move restart pops thirty words
  a_move_pop: assert property (@(posedge i_clk) disable iff (i_reset)
    o_restart_move |-> (o_new_ssp == s_q.sp + FRAME_BYTES) && s_q.fault_status_word[SSW_CM])
    else $error("move restart wrong");
  // a_fmt_error: bad format raises format exception
  a_fmt_error: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.state == AFFR_DECIDE && s_q.fmt != FMT_ACCESS) |=> o_format_error && !o_stk_wr.valid)
    else $error("format error not raised");
  // a_push_slot1: push fault leaves slot one invalid
  a_push_slot1: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_fault && i_fault_info.push) |=> o_writeback1_status == 8'h00 &&
    o_writeback1_address == o_fault_address)
    else $error("push slot one wrong");
  // a_atc_bus: bus error clears translation flag
  a_atc_bus: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_fault && i_fault_info.cause == AFFR_CAUSE_BUS) |=> !o_fault_status_word[SSW_ATC] &&
    !o_fault_status_word[SSW_MA])
    else $error("translation flag on bus error");
  // a_addr_bit0: address error frame has bit 0 clear
  a_addr_bit0: assert property (@(posedge i_clk) disable iff (i_reset)
    o_addr_frame_valid |-> !o_addr_frame_addr[0] && o_addr_frame_pc == $past(i_fault_pc))
    else $error("address error frame wrong");
endmodule // affr_core

// ### testbench/affr_stack_model.sv
// Supervisor stack memory seen by the frame return sequencer.
// Assumes byte addressing, 256 long words, reads answered in the same cycle.
`timescale 1ns/100ps
module affr_stack_model
  import affr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Stack port
  input wire logic [31:0] i_raddr,
  input wire affr_stk_t i_wr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:255];
  // Fill with a changing pattern, so stale reads never look plausible
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'hA5A50000 ^ i;
    end
  end
  // Combinational read, one word a cycle
  assign o_rdata = mem[i_raddr[9:2]];
  // Write pulses land one word each
  always @(posedge i_clk) begin
    if (i_wr.valid) begin
      mem[i_wr.addr[9:2]] <= i_wr.data;
    end
  end
endmodule // affr_stack_model

// ### testbench/access_fault_frame_return_tb.sv
// Self-checking bench for the fault frame builder and return unwinder.
// Assumes the stack model above and a 20 MHz processor clock.
`timescale 1ns/100ps
module access_fault_frame_return_tb
  import affr_pkg::*;
;
  logic clk = 0, reset = 1, fault = 0, mm = 0, tp = 0, pp = 0, up = 0, ae = 0, return_from_exception = 0;
  affr_fault_t fi = '0;
  affr_wb_t w3 = '0, w2 = '0, w1 = '0;
  logic [31:0] cea = 0, fpc = 0, ra = 0, ssp = 0, rdat, raddr, fa, ea, nssp, apc, aad;
  logic [2:0] em = 0, er = 0;
  logic [15:0] fault_status_word;
  logic [7:0] s1, s2, s3, vec;
  logic [31:0] a1, a2, a3, d1, d2, d3;
  logic av, res, rm, reuse, take, fe, busy;
  affr_stk_t wr;
  int n_errors = 0, n_tests = 0;
  initial forever #25 clk = ~clk;
  affr_core i_dut (.i_clk(clk), .i_reset(reset), .i_fault(fault), .i_fault_info(fi),
    .i_multimove(mm), .i_calc_ea(cea), .i_trace_pend(tp), .i_fp_post_pend(pp),
    .i_fp_unimpl_pend(up), .i_wb_int(w3), .i_wb_dmu(w2), .i_wb_bus(w1),
    .i_addr_error(ae), .i_fault_pc(fpc), .i_ref_addr(ra), .i_rte(return_from_exception), .i_ssp(ssp),
    .i_stk_rdata(rdat), .i_ea_mode(em), .i_ea_reg(er), .o_fault_status_word(fault_status_word),
    .o_fault_address(fa), .o_effective_address(ea), .o_writeback1_status(s1),
    .o_writeback2_status(s2), .o_writeback3_status(s3), .o_writeback1_address(a1),
    .o_writeback2_address(a2), .o_writeback3_address(a3), .o_writeback1_data(d1),
    .o_writeback2_data(d2), .o_writeback3_data(d3), .o_addr_frame_valid(av),
    .o_addr_frame_pc(apc), .o_addr_frame_addr(aad), .o_stk_raddr(raddr), .o_stk_wr(wr),
    .o_new_ssp(nssp), .o_resume(res), .o_restart_move(rm), .o_reuse_ea(reuse),
    .o_take_exception(take), .o_vector(vec), .o_format_error(fe), .o_busy(busy));
  affr_stack_model i_stk (.i_clk(clk), .i_raddr(raddr), .i_wr(wr), .o_rdata(rdat));
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus lane placement: left-justify the operand, then rotate by the low address
  function automatic logic [31:0] lane(logic [31:0] d, logic [1:0] sz, logic [1:0] a);
    logic [31:0] x;
    x = d << (8 * (sz == SZ_BYTE ? 3 : sz == SZ_WORD ? 2 : 0));
    return (x >> (8 * a)) | (x << (32 - 8 * a));
  endfunction
  task automatic fault_go(input affr_fault_t f, input logic m, input logic [2:0] pend,
      input logic [15:0] xs, input logic [31:0] xf);
    @(posedge clk);
    fi <= f;
    mm <= m;
    {pp, up, tp} <= pend;
    fault <= 1;
    @(posedge clk);
    fault <= 0;
    @(negedge clk);
    chk("status word", {16'h0, xs}, {16'h0, fault_status_word});
    chk("fault address", xf, fa);
  endtask
  // Handler-built frame at 0x100: format, effective address and status word
  task automatic frame(input logic [3:0] fm, input logic [15:0] sw);
    i_stk.mem[8'h40] = 32'h27000000;
    i_stk.mem[8'h41] = {16'h1234, fm, 12'h008};
    i_stk.mem[8'h42] = 32'h0000C0DE;
    i_stk.mem[8'h43] = {sw, 16'h0000};
  endtask
  task automatic rte_go(input logic [3:0] xr, input logic [31:0] xsp);
    logic [3:0] r;
    r = 4'h0;
    @(posedge clk);
    ssp <= 32'h00000100;
    return_from_exception <= 1;
    @(posedge clk);
    return_from_exception <= 0;
    @(negedge clk);
    chk("busy", 32'h1, {31'h0, busy});
    for (int i = 0; i < 12 && r === 4'h0; i++) begin
      @(negedge clk);
      r = {res, rm, take, fe};
    end
    chk("return kind", {28'h0, xr}, {28'h0, r});
    chk("new stack pointer", xsp, nssp);
    // A return that never answers ends the run at once
    if (r === 4'h0) complete_run();
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    w3 <= '{8'h91, SZ_BYTE, 32'h00002003, 32'h000000EE};
    w2 <= '{8'h92, SZ_WORD, 32'h00002002, 32'h0000BEEF};
    w1 <= '{8'h93, SZ_WORD, 32'h00003001, 32'h0000ABCD};
    cea <= 32'h00004444;
    // locked write, post flag wins over trace
    fault_go('{AFFR_CAUSE_BUS, 0, 0, 1, 0, 0, 0, SZ_WORD, SZ_WORD, 2'h0, 3'h5,
      32'h00003001, 32'h00F03001, 32'h00003001}, 0, 3'b101, 16'h8245, 32'h00003001);
    chk("slot3 data", 32'h000000EE, d3);
    chk("slot2 data", 32'h0000BEEF, d2);
    chk("slot1 data", lane(32'h0000ABCD, SZ_WORD, 2'h1), d1);
    chk("slot1 status", 32'h93, {24'h0, s1});
    chk("slot3 address", 32'h00002003, a3);
    chk("slot2 address", 32'h00002002, a2);
    chk("slot2 status", 32'h92, {24'h0, s2});
    chk("slot3 status", 32'h91, {24'h0, s3});
    // second page line fill, first byte reported
    fault_go('{AFFR_CAUSE_NONRES, 0, 0, 0, 1, 1, 1, SZ_LINE, SZ_BYTE, 2'h1, 3'h2,
      32'h00005000, 32'h00F05000, 32'h00004FFE}, 0, 3'b010, 16'h4D2A, 32'h00004FFE);
    fault_go('{AFFR_CAUSE_BUS, 1, 0, 0, 0, 0, 0, SZ_LINE, SZ_LINE, 2'h0, 3'h0,
      32'h00006000, 32'h00F06000, 32'h00006000}, 0, 3'b000, 16'h0060, 32'h00F06000);
    chk("push slot1 address", 32'h00F06000, a1);
    chk("push slot1 status", 32'h0, {24'h0, s1});
    chk("push data", 32'h0000ABCD, d1);
    // move fault with privilege cause, block-move write
    fault_go('{AFFR_CAUSE_PRIV, 0, 1, 0, 0, 0, 0, SZ_LONG, SZ_LONG, 2'h1, 3'h5,
      32'h00007000, 32'h00F07000, 32'h00007000}, 1, 3'b000, 16'h140D, 32'h00007000);
    chk("saved effective address", 32'h00004444, ea);
    chk("move slot1 status", 32'h0, {24'h0, s1});
    @(posedge clk);
    ae <= 1;
    fpc <= 32'h00008000;
    ra <= 32'h00001235;
    @(posedge clk);
    ae <= 0;
    @(negedge clk);
    chk("addr frame pulse", 32'h1, {31'h0, av});
    chk("addr frame address", 32'h00001234, aad);
    chk("addr frame pc", 32'h00008000, apc);
    frame(FMT_ACCESS, 16'h0000);
    rte_go(4'h8, 32'h0000013C);
    // move restart over four addressing modes
    for (int k = 0; k < 4; k++) begin
      em <= k < 2 ? 3'h7 : k == 2 ? 3'h6 : 3'h5;
      er <= k == 0 ? 3'h2 : 3'h3;
      frame(FMT_ACCESS, 16'h1000);
      rte_go(4'h4, 32'h0000013C);
      chk("reuse address", k < 3, {31'h0, reuse});
      chk("restored address", 32'h0000C0DE, ea);
    end
    // unimplemented floating return uses line vector
    frame(FMT_ACCESS, 16'h4000);
    rte_go(4'h2, 32'h0000013C);
    chk("vector", {24'h0, VEC_FLINE}, {24'h0, vec});
    // Floating post flag return launches the post exception
    frame(FMT_ACCESS, 16'h8000);
    rte_go(4'h2, 32'h0000013C);
    chk("vector", {24'h0, VEC_FP_POST}, {24'h0, vec});
    // trace return shifts three words up
    frame(FMT_ACCESS, 16'h2000);
    rte_go(4'h2, 32'h00000130);
    chk("vector", {24'h0, VEC_TRACE}, {24'h0, vec});
    chk("moved word0", 32'h27000000, i_stk.mem[8'h4C]);
    chk("moved word1", 32'h12342008, i_stk.mem[8'h4D]);
    chk("moved word2", 32'h0000C0DE, i_stk.mem[8'h4E]);
    frame(4'h5, 16'h0000);
    rte_go(4'h1, 32'h000000F8);
    chk("illegal frame kept", 32'h12345008, i_stk.mem[8'h41]);
    complete_run();
  end
endmodule // access_fault_frame_return_tb
